/* File: hw/aps_sequencer.sv */
// Sleep-state power sequencer with APB status and control registers.
//
// Behaviour
// [R1] Start soft-start after standby bias reset
// [R2] Block S3 to S4/S5 and reverse
// [R3] Decode state from two request inputs
// [R4] S4/S5 turns 5V dual off unless variant
// [R5] Deglitch both requests for about 2us
// [R6] 200us delay before entering sleep state
// [R7] Fast charge to 1V, then source
// [R8] First ramp top: standby monitors, 3ms pause
// [R9] Second ramp top: all monitors, hold
// [R10] Ident 1.2V output only when active
// [R11] Active wake waits 25ms after main good
// [R12] Wait end: ramp ident, release gate
// [R13] Active ramp top: discharge to 2.45V, hold
// [R14] Fault high on any output undervoltage
// [R15] External-pass undervoltage: flag only
// [R16] Internal-pass undervoltage: latch that regulator off
// [R17] Soft-start pulled low: fault low, clear latches; here the whole-device latch-off is kept
// [R18] Early standby undervoltage latches whole device off
// [R19] 140C flags fault; 155C latches all off
// [R20] Main input loss forces S4/S5 with fault
// [R21] Forced S4/S5 leaves on main, bias, SS
// [R22] Undriven requests read high
// [R23] Analog levels arrive as comparator bits
// [R24] Timers are counters cleared when cause ends
//
// Chosen here: the register offsets and the APB interface to the registers.
`default_nettype none
module aps_sequencer
    import aps_pkg::*;
#(
    parameter int SLP_DLY_CYC = SLP_DLY_US * CLK_MHZ,
    parameter int SS_WAIT_CYC = SS_WAIT_US * CLK_MHZ,
    parameter int ACT_WAIT_CYC = ACT_WAIT_US * CLK_MHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        suspend_ram_req_n,
    input  wire logic        soft_off_req_n,
    input  wire logic        bias_above_por,
    input  wire logic        main_3v3_good,
    input  wire logic        uv_dual_3v3_output,
    input  wire logic        uv_standby_1v5_output,
    input  wire logic        uv_ident_1v2_output,
    input  wire logic        uv_dual_5v_output,
    input  wire logic        ss_above_1v0,
    input  wire logic        ss_above_1v25,
    input  wire logic        ss_above_2v45,
    input  wire logic        ss_above_2v75,
    input  wire logic        ss_below_0v8,
    input  wire logic        temp_warn_140c,
    input  wire logic        temp_shut_155c,
    output var  logic        ss_fast_charge,
    output var  logic        ss_source_en,
    output var  logic        ss_discharge,
    output var  logic        dual_3v3_output_reg_en,
    output var  logic        standby_1v5_output_en,
    output var  logic        ident_1v2_output_en,
    output var  logic        dual_5v_output_sleep_en,
    output var  logic        dual_switch_gate_release,
    output var  logic        uv_mon_standby_en,
    output var  logic        uv_mon_all_en,
    output var  logic        fault
);

    // Whole state of the block.
    typedef struct packed {
        logic [NIN-1:0]             s1;       // First synchroniser stage.
        logic [NIN-1:0]             s2;       // Second synchroniser stage.
        logic [1:0]                 filt;     // Deglitched requests.
        logic [1:0][DEGL_W-1:0]     fcnt;     // Deglitch counters.
        aps_seq_e                   seq;      // Sequencer state.
        aps_acpi_e                  acpi;     // Accepted power state.
        logic [TMR_W-1:0]           tmr;      // Sequencer timer.
        logic [TMR_W-1:0]           stmr;     // Sleep entry timer.
        logic                       forced;   // Forced S4/S5 after main loss.
        logic                       devlat;   // Whole device latched off.
        logic                       l15;      // Standby 1.5V latched off.
        logic                       l12;      // Ident 1.2V latched off.
        logic                       keep5;    // Variant keeps 5V dual in S4/S5.
        logic                       o_fast;   // Soft-start fast charge.
        logic                       o_src;    // Soft-start current source.
        logic                       o_dis;    // Soft-start discharge.
        logic                       o_reg33;  // 3.3V dual sleep regulator.
        logic                       o_sb15;   // Standby 1.5V regulator.
        logic                       o_id12;   // Ident 1.2V regulator.
        logic                       o_sw5;    // 5V dual sleep switch.
        logic                       o_gate;   // Dual switch gate release.
        logic                       o_monsb;  // Standby undervoltage monitors.
        logic                       o_monall; // All undervoltage monitors.
        logic                       o_fault;  // Fault flag.
        logic                       pready;   // APB ready.
        logic                       pslverr;  // APB error.
        logic [31:0]                prdata;   // APB read data.
    } aps_s;

    aps_s r;  // Registered state.
    aps_s n;  // Next state.

    // Next-state logic for the whole block.
    always_comb begin
        logic sus;
        logic off;
        logic act_path;
        logic uv_any;
        logic late;
        logic [31:0] rd;
        sus = 1'b0;
        off = 1'b0;
        act_path = 1'b0;
        uv_any = 1'b0;
        late = 1'b0;
        rd = 32'h0;
        n = r;
        // Every input from the analog side is synchronised first.
        n.s1 = {temp_shut_155c, temp_warn_140c, ss_below_0v8, ss_above_2v75,
                ss_above_2v45, ss_above_1v25, ss_above_1v0, uv_dual_5v_output,
                uv_ident_1v2_output, uv_standby_1v5_output, uv_dual_3v3_output,
                main_3v3_good, bias_above_por, soft_off_req_n,
                suspend_ram_req_n}; // [R23]
        n.s2 = r.s1;
        // A request only changes after holding steady for the full window.
        for (int i = 0; i < 2; i++) begin
            if (r.s2[i] == r.filt[i]) begin
                n.fcnt[i] = '0;
            end else if (r.fcnt[i] == DEGL_CYC - 1'b1) begin
                n.fcnt[i] = '0;
                n.filt[i] = r.s2[i]; // [R5]
            end else begin
                n.fcnt[i] = r.fcnt[i] + 1'b1;
            end
        end
        sus = r.filt[IN_SUS];
        off = r.filt[IN_OFF];
        act_path = (r.seq == SQ_ARAMP) || (r.seq == SQ_ADIS) || (r.seq == SQ_ACTIVE);
        // Power state decode.
        n.stmr = '0; // [R24]
        if (r.seq == SQ_POR) begin
            // Initial state from the deglitched requests; both high means active wake.
            n.forced = 1'b0;
            if (sus && off) begin
                n.acpi = AC_ACT; // [R11]
            end else if (!sus && off) begin
                n.acpi = AC_S3; // [R3]
            end else if (!sus && !off) begin
                n.acpi = AC_S45;
            end else begin
                n.acpi = AC_S45;
            end
        end else if (r.forced) begin
            // Requests are ignored until the main input recovers, bias is lost or soft-start is pulled low.
            if (r.s2[IN_MAIN]) begin
                n.forced = 1'b0; // [R21]
            end
        end else if (r.acpi == AC_ACT && act_path && !r.s2[IN_MAIN]) begin
            n.forced = 1'b1; // [R20]
            n.acpi = AC_S45;
        end else begin
            case (r.acpi)
                AC_ACT: begin
                    // Suspend low runs the entry timer; soft-off picks the state.
                    if (!sus) begin
                        if (r.stmr == TMR_W'(SLP_DLY_CYC - 1)) begin
                            n.acpi = off ? AC_S3 : AC_S45; // [R6]
                        end else begin
                            n.stmr = r.stmr + 1'b1;
                        end
                    end
                end
                AC_S3: begin
                    // Only a return to active is legal.
                    if (sus && off) begin
                        n.acpi = AC_ACT; // [R2]
                    end
                end
                AC_S45: begin
                    if (sus && off) begin
                        n.acpi = AC_ACT; // [R2]
                    end
                end
                default: begin
                    n.acpi = AC_S45;
                end
            endcase
        end
        // Soft-start sequencer.
        n.tmr = '0; // [R24]
        if (!r.s2[IN_BIAS]) begin
            // Bias loss is the only thing that clears a device latch-off.
            n.seq = SQ_POR;
            n.devlat = 1'b0; // [R18]
            n.l15 = 1'b0;
            n.l12 = 1'b0;
            n.forced = 1'b0; // [R21]
            n.o_monsb = 1'b0;
            n.o_monall = 1'b0;
        end else if (r.devlat) begin
            n.seq = SQ_OFF; // [R19]
        end else if (r.s2[IN_SSLOW]) begin
            // External pull-down shuts all off and restarts on release.
            n.seq = SQ_POR;
            n.l15 = 1'b0; // [R17]
            n.l12 = 1'b0;
            n.forced = 1'b0; // [R21]
            n.o_monsb = 1'b0;
            n.o_monall = 1'b0;
        end else begin
            case (r.seq)
                SQ_POR: begin
                    n.seq = SQ_FAST; // [R1]
                end
                SQ_FAST: begin
                    if (r.s2[IN_SS1]) begin
                        n.seq = SQ_RAMP1; // [R7]
                    end
                end
                SQ_RAMP1: begin
                    if (r.s2[IN_SS275]) begin
                        n.seq = SQ_DIS1;
                        n.o_monsb = 1'b1; // [R8]
                    end
                end
                SQ_DIS1: begin
                    if (!r.s2[IN_SS125]) begin
                        n.seq = SQ_WAIT; // [R8]
                    end
                end
                SQ_WAIT: begin
                    if (r.tmr == TMR_W'(SS_WAIT_CYC - 1)) begin
                        n.seq = SQ_RAMP2; // [R8]
                    end else begin
                        n.tmr = r.tmr + 1'b1;
                    end
                end
                SQ_RAMP2: begin
                    if (r.s2[IN_SS275]) begin
                        n.seq = SQ_DIS2;
                        n.o_monall = 1'b1; // [R9]
                    end
                end
                SQ_DIS2: begin
                    if (!r.s2[IN_SS125]) begin
                        n.seq = SQ_SLEEP; // [R9]
                    end
                end
                SQ_SLEEP: begin
                    if (r.acpi == AC_ACT && !r.forced && r.s2[IN_MAIN]) begin
                        n.seq = SQ_ACTW; // [R11]
                    end
                end
                SQ_ACTW: begin
                    // Any loss of the wake condition restarts the wait.
                    if (r.acpi != AC_ACT || !r.s2[IN_MAIN]) begin
                        n.seq = SQ_SLEEP; // [R24]
                    end else if (r.tmr == TMR_W'(ACT_WAIT_CYC - 1)) begin
                        n.seq = SQ_ARAMP; // [R12]
                    end else begin
                        n.tmr = r.tmr + 1'b1;
                    end
                end
                SQ_ARAMP: begin
                    if (r.acpi != AC_ACT) begin
                        n.seq = SQ_SLEEP;
                    end else if (r.s2[IN_SS275]) begin
                        n.seq = SQ_ADIS; // [R13]
                    end
                end
                SQ_ADIS: begin
                    if (r.acpi != AC_ACT) begin
                        n.seq = SQ_SLEEP;
                    end else if (!r.s2[IN_SS245]) begin
                        n.seq = SQ_ACTIVE; // [R13]
                    end
                end
                SQ_ACTIVE: begin
                    if (r.acpi != AC_ACT) begin
                        n.seq = SQ_SLEEP;
                    end
                end
                SQ_OFF: begin
                    n.seq = SQ_OFF;
                end
                default: begin
                    n.seq = SQ_POR;
                end
            endcase
        end
        // Latch-off sources; a set here wins over any clear above.
        if (r.s2[IN_BIAS] && r.s2[IN_TS]) begin
            n.devlat = 1'b1; // [R19]
        end
        if (r.o_monsb && !r.o_monall && (r.s2[IN_UV33] || r.s2[IN_UV15])) begin
            n.devlat = 1'b1; // [R18]
        end
        if (r.o_monall && r.o_sb15 && r.s2[IN_UV15]) begin
            n.l15 = 1'b1; // [R16]
        end
        if (r.seq == SQ_ACTIVE && r.o_id12 && r.s2[IN_UV12]) begin
            n.l12 = 1'b1; // [R16]
        end
        // Output drives, registered from the next state.
        late = (n.seq == SQ_RAMP2) || (n.seq == SQ_DIS2) || (n.seq == SQ_SLEEP)
            || (n.seq == SQ_ACTW);
        n.o_fast = (n.seq == SQ_FAST); // [R7]
        n.o_src = (n.seq == SQ_FAST) || (n.seq == SQ_RAMP1) || (n.seq == SQ_RAMP2)
            || (n.seq == SQ_ARAMP);
        n.o_dis = ((n.seq == SQ_DIS1) || (n.seq == SQ_DIS2)) && r.s2[IN_SS125]
            || (n.seq == SQ_ADIS) && r.s2[IN_SS245];
        n.o_gate = (n.seq == SQ_ARAMP) || (n.seq == SQ_ADIS) || (n.seq == SQ_ACTIVE); // [R12]
        n.o_reg33 = (n.seq != SQ_POR) && (n.seq != SQ_OFF) && !n.o_gate; // [R1]
        n.o_sb15 = (n.seq != SQ_POR) && (n.seq != SQ_OFF) && !n.l15; // [R16]
        n.o_id12 = n.o_gate && !n.l12; // [R10]
        n.o_sw5 = late && ((n.acpi == AC_S3) || (n.acpi == AC_S45 && r.keep5)); // [R4]
        // Undervoltage on any watched output raises the flag; the latch-offs for it are set above.
        uv_any = r.o_monsb && (r.s2[IN_UV33] || r.s2[IN_UV15])
            || r.o_monall && r.s2[IN_UV5] && (r.o_sw5 || r.o_gate)
            || r.seq == SQ_ACTIVE && r.s2[IN_UV12]; // [R15]
        n.o_fault = !r.s2[IN_SSLOW] && (uv_any || n.devlat || n.forced
            || r.s2[IN_TW] || r.l15 || r.l12); // [R14]
        if (r.s2[IN_SSLOW]) begin
            n.o_fault = 1'b0; // [R17]
        end
        // APB slave: one wait state, unmapped addresses answer an error.
        rd[ST_SEQ_LSB +: 4] = r.seq;
        rd[ST_ACPI_LSB +: 2] = r.acpi;
        rd[ST_FAULT_BIT] = r.o_fault;
        rd[ST_DEVLAT_BIT] = r.devlat;
        rd[ST_L15_BIT] = r.l15;
        rd[ST_L12_BIT] = r.l12;
        rd[ST_FORCED_BIT] = r.forced;
        rd[ST_TWARN_BIT] = r.s2[IN_TW];
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            if (paddr == CTRL_ADDR) begin
                n.prdata[CTRL_KEEP5_BIT] = r.keep5;
                if (pwrite) begin
                    n.keep5 = pwdata[CTRL_KEEP5_BIT];
                end
            end else if (paddr == STAT_ADDR) begin
                n.prdata = pwrite ? 32'h0 : rd;
            end else begin
                n.pslverr = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.s1 <= SYNC_RST; // [R22]
            r.s2 <= SYNC_RST;
            r.filt <= FILT_RST;
            r.seq <= SQ_POR;
            r.acpi <= AC_ACT;
            r.keep5 <= CTRL_KEEP5_RST;
        end else begin
            r <= n;
        end
    end

    // Ports straight from the state register.
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign ss_fast_charge = r.o_fast;
    assign ss_source_en = r.o_src;
    assign ss_discharge = r.o_dis;
    assign dual_3v3_output_reg_en = r.o_reg33;
    assign standby_1v5_output_en = r.o_sb15;
    assign ident_1v2_output_en = r.o_id12;
    assign dual_5v_output_sleep_en = r.o_sw5;
    assign dual_switch_gate_release = r.o_gate;
    assign uv_mon_standby_en = r.o_monsb;
    assign uv_mon_all_en = r.o_monall;
    assign fault = r.o_fault;

    // Checks on the sequencer.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A filtered request only moves when its counter has run out.
    glitch_filter_a: assert property ($changed(r.filt[0]) |-> // [R5]
        $past(r.fcnt[0]) == DEGL_CYC - 1'b1) else $error("request changed early");
    // S3 never turns straight into S4/S5.
    s3_block_a: assert property (r.acpi == AC_S3 |=> r.acpi != AC_S45) // [R2]
        else $error("S3 went to S4/S5");
    // S4/S5 never turns straight into S3.
    s45_block_a: assert property (r.acpi == AC_S45 |=> r.acpi != AC_S3) // [R2]
        else $error("S4/S5 went to S3");
    // The not-allowed request pair keeps the state.
    bad_pair_a: assert property ((r.filt == 2'b01 && r.seq != SQ_POR && !r.forced // [R3]
        && r.s2[IN_MAIN]) |=> $stable(r.acpi)) else $error("bad pair changed state");
    // S3 entry only after the full entry delay.
    sleep_delay_a: assert property (($past(r.acpi) == AC_ACT && r.acpi == AC_S3) // [R6]
        |-> $past(r.stmr) == TMR_W'(SLP_DLY_CYC - 1)) else $error("early sleep");
    // Second ramp follows the full pause.
    ramp_pause_a: assert property (($past(r.seq) == SQ_WAIT && r.seq == SQ_RAMP2) // [R8]
        |-> $past(r.tmr) == TMR_W'(SS_WAIT_CYC - 1)) else $error("short pause");
    // Gate release comes with the end of the active wait.
    gate_release_a: assert property ($rose(r.o_gate) |-> r.seq == SQ_ARAMP // [R12]
        && $past(r.tmr) == TMR_W'(ACT_WAIT_CYC - 1)) else $error("early gate release");
    // Soft-start pulled low drops the fault flag.
    ss_low_a: assert property (r.s2[IN_SSLOW] |=> !r.o_fault) // [R17]
        else $error("fault high with soft-start low");
    // Shutdown temperature latches off the standby 1.5V and 3.3V dual regulators.
    temp_off_a: assert property ((r.s2[IN_TS] && r.s2[IN_BIAS]) |=> r.devlat // [R19]
        ##1 (r.seq == SQ_OFF && !r.o_sb15 && !r.o_reg33 || !r.s2[IN_BIAS]))
        else $error("no thermal shutdown");
    // Main input loss forces S4/S5 with the fault flag.
    forced_s5_a: assert property ((r.seq == SQ_ACTIVE && r.acpi == AC_ACT // [R20]
        && !r.s2[IN_MAIN] && !r.forced && r.s2[IN_BIAS] && !r.s2[IN_SSLOW])
        |=> r.forced && r.acpi == AC_S45 && r.o_fault) else $error("no forced S4/S5");

    reach_active_c: cover property (r.seq == SQ_ADIS ##1 r.seq == SQ_ACTIVE);
    enter_s3_c: cover property (r.acpi == AC_ACT ##1 r.acpi == AC_S3);
    dev_latch_c: cover property ($rose(r.devlat));

endmodule
`default_nettype wire

/* File: hw/aps_pkg.sv */
// Constants, types and register map of the sleep-state power sequencer.
`default_nettype none
package aps_pkg;
    // Clock rate in MHz.
    localparam int CLK_MHZ = 40;
    // Request deglitch window in ns, rounded up to whole cycles.
    localparam int DEGL_NS = 2000;
    localparam int DEGL_W  = 7;
    localparam logic [DEGL_W-1:0] DEGL_CYC = DEGL_W'((DEGL_NS * CLK_MHZ + 999) / 1000);
    // Sleep entry delay, inter-ramp pause and active-entry wait, in us.
    localparam int SLP_DLY_US = 200;
    localparam int SS_WAIT_US = 3000;
    localparam int ACT_WAIT_US = 25000;
    localparam int TMR_W = 20;
    // Register byte offsets on the APB.
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STAT_ADDR = 12'h004;
    // Control fields.
    localparam int CTRL_KEEP5_BIT = 0;
    localparam logic CTRL_KEEP5_RST = 1'h0;
    // Status field positions.
    localparam int ST_SEQ_LSB = 0;
    localparam int ST_ACPI_LSB = 4;
    localparam int ST_FAULT_BIT = 6;
    localparam int ST_DEVLAT_BIT = 7;
    localparam int ST_L15_BIT = 8;
    localparam int ST_L12_BIT = 9;
    localparam int ST_FORCED_BIT = 10;
    localparam int ST_TWARN_BIT = 11;
    // Index of each synchronised input.
    localparam int IN_SUS = 0;
    localparam int IN_OFF = 1;
    localparam int IN_BIAS = 2;
    localparam int IN_MAIN = 3;
    localparam int IN_UV33 = 4;
    localparam int IN_UV15 = 5;
    localparam int IN_UV12 = 6;
    localparam int IN_UV5 = 7;
    localparam int IN_SS1 = 8;
    localparam int IN_SS125 = 9;
    localparam int IN_SS245 = 10;
    localparam int IN_SS275 = 11;
    localparam int IN_SSLOW = 12;
    localparam int IN_TW = 13;
    localparam int IN_TS = 14;
    localparam int NIN = 15;
    // Requests idle high, as their pull-ups make them.
    localparam logic [NIN-1:0] SYNC_RST = 15'h0003;
    localparam logic [1:0] FILT_RST = 2'h3;
    // Sequencer states.
    typedef enum logic [3:0] {
        SQ_POR = 4'h0, SQ_FAST = 4'h1, SQ_RAMP1 = 4'h2, SQ_DIS1 = 4'h3,
        SQ_WAIT = 4'h4, SQ_RAMP2 = 4'h5, SQ_DIS2 = 4'h6, SQ_SLEEP = 4'h7,
        SQ_ACTW = 4'h8, SQ_ARAMP = 4'h9, SQ_ADIS = 4'ha, SQ_ACTIVE = 4'hb,
        SQ_OFF = 4'hc
    } aps_seq_e;
    // Power states requested by the chipset.
    typedef enum logic [1:0] {
        AC_ACT = 2'h0, AC_S3 = 2'h1, AC_S45 = 2'h2
    } aps_acpi_e;
endpackage
`default_nettype wire

/* File: verification/aps_chipset_model.sv */
// Chipset model that drives the two active-low sleep request lines.
`default_nettype none
module aps_chipset_model (
    input  wire logic       pclk,
    input  wire logic       drive_en,
    input  wire logic [1:0] want,
    output var  logic       suspend_ram_req_n,
    output var  logic       soft_off_req_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Levels change just after the edge; a released line floats high on its pull-up.
    always_ff @(posedge pclk) begin
        suspend_ram_req_n <= drive_en ? want[0] : 1'h1;
        soft_off_req_n    <= drive_en ? want[1] : 1'h1;
    end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the sleep-state power sequencer.
`default_nettype none
module testbench
    import aps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fault, err;
    logic        suspend_ram_req_n, soft_off_req_n, bias_above_por, main_3v3_good;
    logic        uv_dual_3v3_output, ss_pull, ss_fast_charge, ss_source_en, ss_discharge;
    logic        ident_1v2_output_en, dual_5v_output_sleep_en, dual_switch_gate_release;
    logic        uv_mon_all_en, drive_en;
    logic        dual_3v3_output_reg_en, standby_1v5_output_en, uv_mon_standby_en, hot;
    logic [1:0]  want;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          ss_mv, failures, samples_checked;
    aps_sequencer #(.SLP_DLY_CYC(20), .SS_WAIT_CYC(50), .ACT_WAIT_CYC(50)) u_aps_sequencer (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .suspend_ram_req_n, .soft_off_req_n, .bias_above_por, .main_3v3_good,
        .uv_dual_3v3_output, .uv_standby_1v5_output(1'h0), .uv_ident_1v2_output(1'h0),
        .uv_dual_5v_output(1'h0), .ss_above_1v0(ss_mv > 1000), .ss_above_1v25(ss_mv > 1250),
        .ss_above_2v45(ss_mv > 2450), .ss_above_2v75(ss_mv > 2750), .ss_below_0v8(ss_pull),
        .temp_warn_140c(1'h0), .temp_shut_155c(hot), .ss_fast_charge, .ss_source_en,
        .ss_discharge, .dual_3v3_output_reg_en, .standby_1v5_output_en,
        .ident_1v2_output_en, .dual_5v_output_sleep_en, .dual_switch_gate_release,
        .uv_mon_standby_en, .uv_mon_all_en, .fault);
    aps_chipset_model u_aps_chipset_model (.pclk, .drive_en, .want, .suspend_ram_req_n,
        .soft_off_req_n);
    // Soft-start node in millivolts, moved by the design's charge and discharge controls.
    always @(posedge pclk) begin
        ss_mv <= (ss_discharge && ss_mv > 0) ? ss_mv - 50 : ss_fast_charge ? ss_mv + 100 :
                 (ss_source_en && ss_mv < 3300) ? ss_mv + 20 : ss_mv;
    end
    // Free-running 40 MHz clock.
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    // Counts a comparison and reports a mismatch at once.
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready is sampled high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Polls the status word until the sequencer shows the wanted state.
    task wait_seq(input aps_seq_e s);
        rd = 32'hffffffff;
        for (int i = 0; i < 400 && rd[3:0] !== s; i++) apb(1'h0, STAT_ADDR, 32'h0);
        check("sequencer state", rd[3:0], s);
        repeat (2) @(posedge pclk);
    endtask
    task note(input string n);
        $display("test %s done after %0d checks", n, samples_checked);
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cuts a hang short well after the tests should have ended.
    initial begin
        #2ms;
        failures++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, err} = '0;
        {bias_above_por, main_3v3_good, uv_dual_3v3_output, ss_pull, drive_en} = 5'h18;
        {want, failures, samples_checked, ss_mv, hot} = '0;
        want = 2'h3;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        // Floating request lines: both ramps, then the active path.
        wait_seq(SQ_ACTIVE);
        check("gate release", dual_switch_gate_release, 1'h1);
        check("ident enable", ident_1v2_output_en, 1'h1);
        check("all monitors", uv_mon_all_en, 1'h1);
        check("no fault", fault, 1'h0);
        check("3v3 regulator", dual_3v3_output_reg_en, 1'h0);
        check("1v5 enable", standby_1v5_output_en, 1'h1);
        check("standby monitors", uv_mon_standby_en, 1'h1);
        note("power-up");
        // A one-microsecond suspend glitch must be filtered out.
        drive_en <= 1'h1;
        want <= 2'h2;
        repeat (40) @(posedge pclk);
        want <= 2'h3;
        repeat (150) @(posedge pclk);
        apb(1'h0, STAT_ADDR, 32'h0);
        check("acpi after glitch", rd[5:4], AC_ACT);
        want <= 2'h2;
        wait_seq(SQ_SLEEP);
        check("acpi s3", rd[5:4], AC_S3);
        check("gate in s3", dual_switch_gate_release, 1'h0);
        check("ident in s3", ident_1v2_output_en, 1'h0);
        check("5v in s3", dual_5v_output_sleep_en, 1'h1);
        // Direct move from S3 to S4/S5 is refused.
        want <= 2'h0;
        repeat (200) @(posedge pclk);
        apb(1'h0, STAT_ADDR, 32'h0);
        check("acpi stays s3", rd[5:4], AC_S3);
        want <= 2'h1;
        repeat (200) @(posedge pclk);
        apb(1'h0, STAT_ADDR, 32'h0);
        check("bad pair keeps s3", rd[5:4], AC_S3);
        note("suspend");
        want <= 2'h3;
        wait_seq(SQ_ACTIVE);
        want <= 2'h0;
        wait_seq(SQ_SLEEP);
        check("acpi s45", rd[5:4], AC_S45);
        check("5v off in s45", dual_5v_output_sleep_en, 1'h0);
        apb(1'h1, CTRL_ADDR, 32'h1);
        apb(1'h0, CTRL_ADDR, 32'h0);
        check("control word", rd, 32'h1);
        check("5v kept in s45", dual_5v_output_sleep_en, 1'h1);
        apb(1'h0, 12'h008, 32'h0);
        check("unmapped error", err, 1'h1);
        check("unmapped data", rd, 32'h0);
        note("soft-off");
        want <= 2'h3;
        wait_seq(SQ_ACTIVE);
        uv_dual_3v3_output <= 1'h1;
        repeat (10) @(posedge pclk);
        check("fault on uv", fault, 1'h1);
        apb(1'h0, STAT_ADDR, 32'h0);
        check("no device latch", rd[7], 1'h0);
        uv_dual_3v3_output <= 1'h0;
        main_3v3_good <= 1'h0;
        repeat (200) @(posedge pclk);
        apb(1'h0, STAT_ADDR, 32'h0);
        check("forced flag", rd[10], 1'h1);
        check("forced acpi", rd[5:4], AC_S45);
        check("fault when forced", fault, 1'h1);
        ss_pull <= 1'h1;
        repeat (10) @(posedge pclk);
        check("fault when pulled", fault, 1'h0);
        ss_pull <= 1'h0;
        hot <= 1'h1;
        repeat (10) @(posedge pclk);
        check("fault when hot", fault, 1'h1);
        check("1v5 off when hot", standby_1v5_output_en, 1'h0);
        note("faults");
        stop_test();
    end
endmodule
`default_nettype wire
